// ### rtl/external_line_event_unit.sv
// external line event unit: edge select, masks, pending store, ahb-lite slave
`timescale 1ns/100ps
module external_line_event_unit
  import line_event_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 ce,
  input  wire logic [PIN_CNT-1:0]   gpio_pins,
  input  wire logic [INNER_CNT-1:0] inner_lines,
  input  wire logic                 hsel,
  input  wire logic [DATA_W-1:0]    haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [DATA_W-1:0]    hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic      [DATA_W-1:0]    hrdata,
  output logic      [LINE_CNT-1:0]  irq_req,
  output logic      [LINE_CNT-1:0]  evt_req
);

  // ==========================================================
  // declarations
  bus_state_t            state_r, state_nxt;
  logic [ADDR_W-1:0]     addr_r, addr_nxt;
  logic                  wr_r, wr_nxt;
  logic                  hready_nxt;
  logic [DATA_W-1:0]     hrdata_nxt;
  logic                  accept;
  logic                  wr_en;
  logic                  rd_en;

  logic [LINE_CNT-1:0]   irq_mask_r, irq_mask_nxt;
  logic [LINE_CNT-1:0]   evt_mask_r, evt_mask_nxt;
  logic [LINE_CNT-1:0]   rise_sel_r, rise_sel_nxt;
  logic [LINE_CNT-1:0]   fall_sel_r, fall_sel_nxt;
  logic [LINE_CNT-1:0]   pend_r, pend_nxt;
  logic [DATA_W-1:0]     pin_sel0_r, pin_sel0_nxt;
  logic [DATA_W-1:0]     pin_sel1_r, pin_sel1_nxt;
  logic [LINE_CNT-1:0]   irq_req_nxt;
  logic [LINE_CNT-1:0]   evt_req_nxt;

  logic [PIN_LINE_CNT-1:0] pin_lines;
  logic [LINE_CNT-1:0]     all_lines;
  logic [LINE_CNT-1:0]     rise_evt;
  logic [LINE_CNT-1:0]     fall_evt;
  logic [LINE_CNT-1:0]     edge_hit;
  logic [LINE_CNT-1:0]     pend_set;
  logic [LINE_CNT-1:0]     pend_clr;
  logic [LINE_CNT-1:0]     wdata_line;

  // ==========================================================
  // line sources
  pin_line_mux u_pin_line_mux (
    .pins      (gpio_pins),
    .sel_words ({pin_sel1_r, pin_sel0_r}),
    .lines     (pin_lines)
  );

  assign all_lines = {inner_lines, pin_lines};

  edge_catcher u_edge_catcher (
    .clock    (clock),
    .srst     (srst),
    .ce       (ce),
    .line_in  (all_lines),
    .rise_evt (rise_evt),
    .fall_evt (fall_evt)
  );

  // ==========================================================
  // bus handshake: one wait state, then the data phase completes
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wr_en  = (state_r == BUS_WAIT) && wr_r;
  assign rd_en  = (state_r == BUS_WAIT) && !wr_r;

  always_comb begin
    state_nxt  = state_r;
    addr_nxt   = addr_r;
    wr_nxt     = wr_r;
    hready_nxt = hreadyout;
    unique case (state_r)
      BUS_IDLE: begin
        if (accept) begin
          state_nxt  = BUS_WAIT;
          addr_nxt   = haddr[ADDR_W-1:0];
          wr_nxt     = hwrite;
          hready_nxt = 1'b0;
        end
      end
      BUS_WAIT: begin
        state_nxt  = BUS_IDLE;
        hready_nxt = 1'b1;
      end
      default: begin
        state_nxt  = BUS_IDLE;
        hready_nxt = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // read mux, loaded at the end of the wait state
  always_comb begin
    hrdata_nxt = hrdata;
    if (rd_en) begin
      unique case (addr_r)
        IRQ_MASK_OFS: hrdata_nxt = {{(DATA_W-LINE_CNT){1'b0}}, irq_mask_r};
        EVT_MASK_OFS: hrdata_nxt = {{(DATA_W-LINE_CNT){1'b0}}, evt_mask_r};
        RISE_SEL_OFS: hrdata_nxt = {{(DATA_W-LINE_CNT){1'b0}}, rise_sel_r};
        FALL_SEL_OFS: hrdata_nxt = {{(DATA_W-LINE_CNT){1'b0}}, fall_sel_r};
        PENDING_OFS:  hrdata_nxt = {{(DATA_W-LINE_CNT){1'b0}}, pend_r};
        PIN_SEL0_OFS: hrdata_nxt = pin_sel0_r;
        PIN_SEL1_OFS: hrdata_nxt = pin_sel1_r;
        default:      hrdata_nxt = ZERO_WORD;
      endcase
    end
  end

  // ==========================================================
  // configuration registers
  assign wdata_line = hwdata[LINE_CNT-1:0];

  always_comb begin
    irq_mask_nxt = irq_mask_r;
    evt_mask_nxt = evt_mask_r;
    rise_sel_nxt = rise_sel_r;
    fall_sel_nxt = fall_sel_r;
    pin_sel0_nxt = pin_sel0_r;
    pin_sel1_nxt = pin_sel1_r;
    if (wr_en) begin
      unique case (addr_r)
        IRQ_MASK_OFS: irq_mask_nxt = wdata_line;
        EVT_MASK_OFS: evt_mask_nxt = wdata_line;
        RISE_SEL_OFS: rise_sel_nxt = wdata_line;
        FALL_SEL_OFS: fall_sel_nxt = wdata_line;
        PIN_SEL0_OFS: pin_sel0_nxt = hwdata & SEL_WR_MASK;
        PIN_SEL1_OFS: pin_sel1_nxt = hwdata & SEL_WR_MASK;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // edge qualification, pending store and request outputs
  always_comb begin
    edge_hit = (rise_evt & rise_sel_r) | (fall_evt & fall_sel_r);
    pend_set = edge_hit & irq_mask_r;
    pend_clr = '0;
    if (wr_en && addr_r == SOFT_TRIG_OFS) begin
      pend_set = pend_set | (wdata_line & irq_mask_r);
    end
    if (wr_en && addr_r == PENDING_OFS) begin
      pend_clr = wdata_line;
    end
    pend_nxt    = (pend_r & ~pend_clr) | pend_set;
    irq_req_nxt = pend_r & irq_mask_r;
    evt_req_nxt = edge_hit & evt_mask_r;
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r    <= BUS_IDLE;
      addr_r     <= '0;
      wr_r       <= 1'b0;
      hreadyout  <= 1'b1;
      hresp      <= RESP_OKAY;
      hrdata     <= ZERO_WORD;
      irq_mask_r <= LINE_RST;
      evt_mask_r <= LINE_RST;
      rise_sel_r <= LINE_RST;
      fall_sel_r <= LINE_RST;
      pend_r     <= LINE_RST;
      pin_sel0_r <= SEL_RST;
      pin_sel1_r <= SEL_RST;
      irq_req    <= LINE_RST;
      evt_req    <= LINE_RST;
    end else if (ce) begin
      state_r    <= state_nxt;
      addr_r     <= addr_nxt;
      wr_r       <= wr_nxt;
      hreadyout  <= hready_nxt;
      hresp      <= RESP_OKAY;
      hrdata     <= hrdata_nxt;
      irq_mask_r <= irq_mask_nxt;
      evt_mask_r <= evt_mask_nxt;
      rise_sel_r <= rise_sel_nxt;
      fall_sel_r <= fall_sel_nxt;
      pend_r     <= pend_nxt;
      pin_sel0_r <= pin_sel0_nxt;
      pin_sel1_r <= pin_sel1_nxt;
      irq_req    <= irq_req_nxt;
      evt_req    <= evt_req_nxt;
    end
  end

endmodule

// ### rtl/line_event_pkg.sv
// constants, register map and bus encodings of the external line event unit
// Function
// - nineteen separate edge lines, each raising an interrupt or event request
// - each line selects rising, falling or both edges by software
// - each line has its own interrupt mask and event mask; each mask blocks only its own request
// - pending bit per line records requests, readable until software clears
// - edges shorter than one clock period are still caught
// - first sixteen lines fed from 112 pins through a selection multiplexer
package line_event_pkg;

  // ==========================================================
  // sizes
  localparam int LINE_CNT      = 19;
  localparam int PIN_LINE_CNT  = 16;
  localparam int PORT_CNT      = 7;
  localparam int PIN_CNT       = PORT_CNT * PIN_LINE_CNT;
  localparam int INNER_CNT     = LINE_CNT - PIN_LINE_CNT;
  localparam int SEL_W         = 3;
  localparam int SEL_FIELD_W   = 4;
  localparam int SELS_PER_WORD = 8;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] EVT_MASK_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] RISE_SEL_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] FALL_SEL_OFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] SOFT_TRIG_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] PENDING_OFS   = 8'h14;
  localparam logic [ADDR_W-1:0] PIN_SEL0_OFS  = 8'h18;
  localparam logic [ADDR_W-1:0] PIN_SEL1_OFS  = 8'h1c;

  // ==========================================================
  // reset values and field masks
  localparam logic [LINE_CNT-1:0] LINE_RST    = 19'h00000;
  localparam logic [DATA_W-1:0]   SEL_RST     = 32'h00000000;
  localparam logic [DATA_W-1:0]   SEL_WR_MASK = 32'h77777777;
  localparam logic [DATA_W-1:0]   ZERO_WORD   = 32'h00000000;

  // ==========================================================
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       RESP_OKAY     = 1'h0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_WAIT = 2'b10
  } bus_state_t;

endpackage

// ### rtl/pin_line_mux.sv
// selects one pin port per line for the sixteen pin-fed lines
`timescale 1ns/100ps
module pin_line_mux
  import line_event_pkg::*;
(
  input  wire logic [PIN_CNT-1:0]      pins,
  input  wire logic [2*DATA_W-1:0]     sel_words,
  output logic      [PIN_LINE_CNT-1:0] lines
);

  // ==========================================================
  // per line port selection; codes past the last port read low
  genvar i;
  generate
    for (i = 0; i < PIN_LINE_CNT; i++) begin : g_line
      logic [SEL_W-1:0] sel;
      assign sel = sel_words[i*SEL_FIELD_W +: SEL_W];
      assign lines[i] = (int'(sel) < PORT_CNT) ? pins[int'(sel)*PIN_LINE_CNT + i]
                                               : 1'b0;
    end
  endgenerate

endmodule

// ### rtl/edge_catcher.sv
// catches short pulses with line-clocked toggles and syncs them to the clock
`timescale 1ns/100ps
module edge_catcher
  import line_event_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic                ce,
  input  wire logic [LINE_CNT-1:0] line_in,
  output logic      [LINE_CNT-1:0] rise_evt,
  output logic      [LINE_CNT-1:0] fall_evt
);

  genvar i;
  generate
    for (i = 0; i < LINE_CNT; i++) begin : g_line
      logic rise_tgl_r;
      logic fall_tgl_r;
      logic rise_s1_r, rise_s2_r, rise_seen_r;
      logic fall_s1_r, fall_s2_r, fall_seen_r;
      logic rise_evt_nxt, fall_evt_nxt;

      // ==========================================================
      // toggles clocked by the line itself, so no pulse is too short
      always_ff @(posedge line_in[i] or posedge srst) begin
        if (srst) begin
          rise_tgl_r <= 1'b0;
        end else begin
          rise_tgl_r <= ~rise_tgl_r;
        end
      end

      always_ff @(negedge line_in[i] or posedge srst) begin
        if (srst) begin
          fall_tgl_r <= 1'b0;
        end else begin
          fall_tgl_r <= ~fall_tgl_r;
        end
      end

      // ==========================================================
      // two flop sync, then toggle change becomes a one cycle pulse
      always_comb begin
        rise_evt_nxt = rise_s2_r ^ rise_seen_r;
        fall_evt_nxt = fall_s2_r ^ fall_seen_r;
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          rise_s1_r   <= 1'b0;
          rise_s2_r   <= 1'b0;
          rise_seen_r <= 1'b0;
          fall_s1_r   <= 1'b0;
          fall_s2_r   <= 1'b0;
          fall_seen_r <= 1'b0;
          rise_evt[i] <= 1'b0;
          fall_evt[i] <= 1'b0;
        end else if (ce) begin
          rise_s1_r   <= rise_tgl_r;
          rise_s2_r   <= rise_s1_r;
          rise_seen_r <= rise_s2_r;
          fall_s1_r   <= fall_tgl_r;
          fall_s2_r   <= fall_s1_r;
          fall_seen_r <= fall_s2_r;
          rise_evt[i] <= rise_evt_nxt;
          fall_evt[i] <= fall_evt_nxt;
        end
      end
    end
  endgenerate

endmodule

// ### bench/line_source_model.sv
// pin and inner line source standing in for the far side of the unit
`timescale 1ns/100ps
module line_source_model
  import line_event_pkg::*;
(
  output logic [PIN_CNT-1:0]   gpio_pins,
  output logic [INNER_CNT-1:0] inner_lines
);
  logic [PIN_CNT+INNER_CNT-1:0] lvl;
  assign {inner_lines, gpio_pins} = lvl;
  initial lvl = '0;
  // set one source level, pins then inner lines
  task automatic set_src(input int n, input logic v);
    lvl[n] <= v;
  endtask
  // pulse far shorter than one clock period
  task automatic blip(input int n);
    lvl[n] <= ~lvl[n];
    #8;
    lvl[n] <= ~lvl[n];
  endtask
endmodule

// ### bench/line_event_checker.sv
// port checker for the external line event unit
`timescale 1ns/100ps
module line_event_checker
  import line_event_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 srst,
  input wire logic                 ce,
  input wire logic [PIN_CNT-1:0]   gpio_pins,
  input wire logic [INNER_CNT-1:0] inner_lines,
  input wire logic                 hsel,
  input wire logic [DATA_W-1:0]    haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [2:0]           hsize,
  input wire logic [DATA_W-1:0]    hwdata,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [DATA_W-1:0]    hrdata,
  input wire logic [LINE_CNT-1:0]  irq_req,
  input wire logic [LINE_CNT-1:0]  evt_req
);
  logic       take;
  logic [2:0] age_r;
  logic [2:0] age_nxt;
  logic       unm_r;
  logic       unm_nxt;
  assign take = hsel && hready && htrans[1] && ce && hreadyout;
  always_comb begin
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    unm_nxt = unm_r;
    if (take) begin
      unm_nxt = !hwrite && (haddr[7:0] >= 8'h20 || haddr[7:0] == SOFT_TRIG_OFS);
    end
    if (take && hwrite) begin
      age_nxt = 3'h0;
    end
    if (srst) begin
      age_nxt = 3'h7;
      unm_nxt = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    age_r <= age_nxt;
    unm_r <= unm_nxt;
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_reset_quiet: assert property ($fell(srst) |-> hreadyout && hrdata == 32'h0 &&
    irq_req == '0 && evt_req == '0) else $error("outputs not cleared by reset");
  a_wait_one: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("transfer wait not one cycle");
  a_wait_bound: assert property (!hreadyout && ce |=> hreadyout)
    else $error("ready low too long");
  a_resp_okay: assert property (hresp == RESP_OKAY) else $error("response not okay");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $past(!hreadyout))
    else $error("read data moved outside a read");
  a_frozen_ce: assert property (!ce |=> $stable(hreadyout) && $stable(hrdata) &&
    $stable(irq_req) && $stable(evt_req)) else $error("state moved with ce low");
  a_irq_drop_write: assert property (|($past(irq_req) & ~irq_req) |-> age_r <= 3'h3)
    else $error("request dropped without a write");
  a_unmapped_zero: assert property (unm_r && !hreadyout |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  c_write: cover property (take && hwrite);
  c_evt: cover property (evt_req != '0);
  c_irq_clear: cover property (irq_req != '0 ##1 irq_req == '0);
endmodule
bind external_line_event_unit line_event_checker chk (.clock(clock), .srst(srst), .ce(ce),
  .gpio_pins(gpio_pins), .inner_lines(inner_lines), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_req(irq_req),
  .evt_req(evt_req));

// ### bench/tb_top.sv
// testbench for the external line event unit
`timescale 1ns/100ps
module tb_top
  import line_event_pkg::*;
;
  logic                 clock = 1'b0;
  logic                 srst = 1'b1;
  logic                 ce = 1'b1;
  logic                 hsel = 1'b0;
  logic                 hwrite = 1'b0;
  logic [1:0]           htrans = 2'h0;
  logic [2:0]           hsize = 3'h2;
  logic [DATA_W-1:0]    haddr = 32'h0;
  logic [DATA_W-1:0]    hwdata = 32'h0;
  logic                 hreadyout;
  logic                 hresp;
  logic [DATA_W-1:0]    hrdata;
  logic [LINE_CNT-1:0]  irq_req;
  logic [LINE_CNT-1:0]  evt_req;
  logic [PIN_CNT-1:0]   gpio_pins;
  logic [INNER_CNT-1:0] inner_lines;
  int                   errors = 0;
  int                   total_checks = 0;
  int                   evt_cnt = 0;
  int                   watch = 3;
  always #12.5 clock = ~clock;
  always @(posedge clock) if (evt_req[watch] === 1'b1) evt_cnt++;
  external_line_event_unit DUT (.clock(clock), .srst(srst), .ce(ce), .gpio_pins(gpio_pins),
    .inner_lines(inner_lines), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_req(irq_req),
    .evt_req(evt_req));
  line_source_model src (.gpio_pins(gpio_pins), .inner_lines(inner_lines));
  // ==========================================
  // bus and check tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    total_checks++;
    if (got !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    logic [DATA_W-1:0] e;
    wait_n(3);
    srst <= 1'b0;
    wait_n(1);
    for (int a = 0; a < 9; a++) rd_chk(8'(a * 4), 32'h0);
    wr(8'h24, 32'hffffffff);
    rd_chk(8'h24, 32'h0);
    wr(PIN_SEL0_OFS, 32'hffffffff);
    rd_chk(PIN_SEL0_OFS, SEL_WR_MASK);
    wr(PIN_SEL0_OFS, 32'h00600000);
    wr(IRQ_MASK_OFS, 32'h0003ffff);
    wr(EVT_MASK_OFS, 32'hffffffff);
    rd_chk(EVT_MASK_OFS, 32'h0007ffff);
    for (int m = 1; m < 4; m++) begin
      wr(RISE_SEL_OFS, m[0] ? 32'h8 : 32'h0);
      wr(FALL_SEL_OFS, m[1] ? 32'h8 : 32'h0);
      for (int v = 1; v >= 0; v--) begin
        evt_cnt = 0;
        src.set_src(3, v[0]);
        wait_n(8);
        e = (v == 1 ? m[0] : m[1]) ? 32'h8 : 32'h0;
        rd_chk(PENDING_OFS, e);
        cmp(32'(evt_cnt), e >> 3);
        cmp({13'h0, irq_req}, e);
        wr(PENDING_OFS, 32'h8);
      end
    end
    wr(RISE_SEL_OFS, 32'h00060020);
    wr(FALL_SEL_OFS, 32'h0);
    src.blip(5);
    wait_n(8);
    rd_chk(PENDING_OFS, 32'h0);
    src.blip(6 * 16 + 5);
    src.blip(113);
    src.blip(114);
    wait_n(8);
    rd_chk(PENDING_OFS, 32'h00020020);
    cmp({13'h0, irq_req}, 32'h00020020);
    wr(PENDING_OFS, 32'h0);
    rd_chk(PENDING_OFS, 32'h00020020);
    wr(PENDING_OFS, 32'h20);
    rd_chk(PENDING_OFS, 32'h00020000);
    wr(SOFT_TRIG_OFS, 32'hffffffff);
    rd_chk(PENDING_OFS, 32'h0003ffff);
    rd_chk(SOFT_TRIG_OFS, 32'h0);
    wr(PENDING_OFS, 32'hffffffff);
    wait_n(2);
    cmp({13'h0, irq_req}, 32'h0);
    wr(PIN_SEL1_OFS, 32'h00000002);
    wr(RISE_SEL_OFS, 32'h00000100);
    src.blip(2 * 16 + 8);
    wait_n(8);
    rd_chk(PENDING_OFS, 32'h00000100);
    wr(PENDING_OFS, 32'h00000100);
    wr(RISE_SEL_OFS, 32'h00060020);
    wr(EVT_MASK_OFS, 32'h0);
    watch = 5;
    evt_cnt = 0;
    src.blip(6 * 16 + 5);
    wait_n(8);
    cmp(32'(evt_cnt), 32'h0);
    rd_chk(PENDING_OFS, 32'h20);
    ce <= 1'b0;
    wait_n(3);
    ce <= 1'b1;
    srst <= 1'b1;
    wait_n(3);
    srst <= 1'b0;
    wait_n(1);
    rd_chk(IRQ_MASK_OFS, 32'h0);
    rd_chk(PENDING_OFS, 32'h0);
    print_verdict();
  end
  initial begin
    #1000000;
    errors++;
    print_verdict();
  end
endmodule
